/* File: design/sau_pkg.sv */
// sau_pkg: register map, subcommand codes, timing and state type of the access block
package sau_pkg;
	localparam int unsigned AXI_AW = 12;
	// printed register indices; byte address is four times the index
	localparam logic [11:0] IDX_PART_ID = 12'h001;
	localparam logic [11:0] IDX_FW_WORDS = 12'h002;
	localparam logic [11:0] IDX_SI_REV = 12'h003;
	localparam logic [11:0] IDX_KEY_PAIR = 12'h035;
	localparam logic [11:0] IDX_RECOVERY = 12'h09B;
	localparam logic [11:0] ADDR_PART_ID = {IDX_PART_ID[9:0], 2'b00};
	localparam logic [11:0] ADDR_FW_LOW = {IDX_FW_WORDS[9:0], 2'b00};
	localparam logic [11:0] ADDR_SI_REV = {IDX_SI_REV[9:0], 2'b00};
	localparam logic [11:0] ADDR_KEY_PAIR = {IDX_KEY_PAIR[9:0], 2'b00};
	localparam logic [11:0] ADDR_RECOVERY = {IDX_RECOVERY[9:0], 2'b00};
	localparam logic [11:0] ADDR_COMMAND = 12'h100;
	localparam logic [11:0] ADDR_FW_HIGH = 12'h104;
	localparam logic [11:0] ADDR_REG_CTL = 12'h108;
	localparam logic [11:0] ADDR_STATUS = 12'h10C;
	localparam logic [11:0] ADDR_REG_DEFAULT = 12'h110;
	// subcommand codes
	localparam logic [15:0] CMD_RESET = 16'h0012;
	localparam logic [15:0] CMD_SWITCH_TOGGLE = 16'h0022;
	localparam logic [15:0] CMD_LOCK = 16'h0030;
	localparam logic [15:0] CMD_ENTER_EDIT = 16'h0090;
	localparam logic [15:0] CMD_LEAVE_EDIT = 16'h0092;
	// field layout
	localparam int unsigned REGCTL_EN_BIT = 3;
	localparam int unsigned REGCTL_TS_BIT = 4;
	localparam logic [7:0] REGCTL_MASK = 8'h1F;
	localparam logic [7:0] RECOVERY_MASK = 8'hFE;
	localparam int unsigned ST_LOCKED_BIT = 0;
	localparam int unsigned ST_EDIT_BIT = 1;
	localparam int unsigned ST_AUTO_BIT = 2;
	localparam int unsigned ST_KEY_BIT = 3;
	// values after reset
	localparam logic [7:0] REG_DEFAULT_RESET = 8'h08;
	localparam logic LOCKED_RESET = 1'b1;
	localparam logic AUTONOMOUS_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// unlock window
	localparam longint unsigned CLK_HZ = 40_000_000;
	localparam longint unsigned KEY_WINDOW_S = 5;
	localparam longint unsigned KEY_WINDOW_CYC = KEY_WINDOW_S * CLK_HZ;

	typedef struct packed {
		logic aw_have;
		logic [11:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic locked;
		logic edit_mode;
		logic autonomous;
		logic key_stage;
		logic [31:0] key_timer;
		logic [31:0] key_pair;
		logic [7:0] recovery;
		logic [7:0] reg_ctl;
		logic [7:0] reg_default;
		logic [12:0] reg_mv;
		logic dev_reset;
	} sau_state_t;

	// regulator select code to millivolts
	function automatic logic [12:0] sau_vsel_mv(input logic [2:0] code);
		case (code)
			3'h4: sau_vsel_mv = 13'h09C4;
			3'h5: sau_vsel_mv = 13'h0BB8;
			3'h6: sau_vsel_mv = 13'h0CE4;
			3'h7: sau_vsel_mv = 13'h1388;
			default: sau_vsel_mv = 13'h0708;
		endcase
	endfunction
endpackage

/* File: design/sau_top.sv */
// sau_top: subcommand decoder, unlock sequence and regulator control behind AXI4-Lite
// Contract
// - regulator output follows regulator enable bit
// - voltage select decodes to 1.8/2.5/3.0/3.3/5 V
// - code 0x0012 unlocked resets the device
// - code 0x0022 unlocked toggles autonomous switch control
// - code 0x0030 unlocked enters locked mode
// - code 0x0090 unlocked enters settings edit
// - code 0x0092 unlocked leaves settings edit
// - part identifier readable in both modes
// - firmware words: legacy id, version, build
// - silicon revision readable in both modes
// - two-word key, writable only when unlocked
// - unlock only after both correct words
// - recovery register read-only locked, bit0 reserved
// - bits 7,6 trigger voltage and diagnostic recovery
// - bits 5,4 trigger short-circuit and overcurrent-one recovery
// - bits 3,2 trigger overcurrent-two and charge recovery
// - bit 1 triggers temperature recovery
// - leaving edit loads regulator fields from defaults
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sau_top import sau_pkg::*; #(
	parameter logic [15:0] PART_ID = 16'hA5C3, // arbitrary
	parameter logic [15:0] FIRMWARE_REVISION_WORDS = 16'h0102, // arbitrary
	parameter logic [15:0] BUILD_NUM = 16'h0001, // arbitrary
	parameter logic [15:0] SI_REV = 16'h0011, // arbitrary
	parameter logic [15:0] KEY_FIRST_INIT = 16'h1234,
	parameter logic [15:0] KEY_SECOND_INIT = 16'h5678,
	parameter longint unsigned KEY_TIMEOUT_CYC = KEY_WINDOW_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// axi4-lite write address
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// regulator
	output logic aux_regulator_output,
	output logic [2:0] regulator_voltage_select,
	output logic [12:0] regulator_millivolts,
	output logic ts_pullup_on,
	// modes
	output logic unlocked_access_mode,
	output logic settings_edit_mode,
	output logic autonomous_switch_control,
	output logic device_reset_pulse,
	// fault recovery triggers
	output logic cell_voltage_recovery,
	output logic diagnostic_recovery,
	output logic short_circuit_recovery,
	output logic discharge_overcurrent_one_recovery,
	output logic discharge_overcurrent_two_recovery,
	output logic charge_overcurrent_recovery,
	output logic temperature_recovery
);

	if (KEY_TIMEOUT_CYC < 1 || KEY_TIMEOUT_CYC > 64'h0000_0000_FFFF_FFFF) begin : g_chk_timeout
		$error("KEY_TIMEOUT_CYC must lie in 1 .. 2**32-1");
	end
	if (KEY_FIRST_INIT == KEY_SECOND_INIT) begin : g_chk_keys
		$error("key words must differ");
	end

	localparam logic [31:0] TIMEOUT_LOAD = 32'(KEY_TIMEOUT_CYC - 1);

	localparam sau_state_t ST_RST = '{
		aw_have: 1'b0, aw_addr: 12'h000, w_have: 1'b0, w_data: 32'h0000_0000,
		w_strb: 4'h0, awready: 1'b0, wready: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY,
		arready: 1'b0, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000,
		locked: LOCKED_RESET, edit_mode: 1'b0, autonomous: AUTONOMOUS_RESET,
		key_stage: 1'b0, key_timer: 32'h0000_0000,
		key_pair: {KEY_SECOND_INIT, KEY_FIRST_INIT}, recovery: 8'h00,
		reg_ctl: REG_DEFAULT_RESET, reg_default: REG_DEFAULT_RESET,
		reg_mv: sau_vsel_mv(REG_DEFAULT_RESET[2:0]), dev_reset: 1'b0
	};

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [1:0] rst_sync_q;
	logic rst_n;
	sau_state_t s_q;
	sau_state_t s_d;

	// release is synchronised; assertion still asynchronous
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_comb begin
		logic [15:0] code;
		logic wr_go;
		logic soft_reset;
		logic [31:0] m;
		code = 16'h0000;
		wr_go = 1'b0;
		soft_reset = 1'b0;
		m = 32'h0000_0000;
		s_d = s_q;
		s_d.dev_reset = 1'b0;

		// unlock window runs down while a first word is pending
		if (s_q.key_stage) begin
			if (s_q.key_timer == 32'h0000_0000) begin
				s_d.key_stage = 1'b0;
			end else begin
				s_d.key_timer = s_q.key_timer - 32'h0000_0001;
			end
		end

		// write channels taken independently, in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
		if (wr_go) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			// any other write breaks a pending key sequence
			s_d.key_stage = 1'b0;
			case (s_q.aw_addr)
				ADDR_COMMAND: begin
					code = s_q.w_data[15:0];
					if (s_q.locked) begin
						if (s_q.key_stage && code == s_q.key_pair[31:16]) begin
							s_d.locked = 1'b0;
						end else if (code == s_q.key_pair[15:0]) begin
							s_d.key_stage = 1'b1;
							s_d.key_timer = TIMEOUT_LOAD;
						end
					end else begin
						case (code)
							CMD_RESET: begin
								soft_reset = 1'b1;
							end
							CMD_SWITCH_TOGGLE: begin
								s_d.autonomous = !s_q.autonomous;
							end
							CMD_LOCK: begin
								s_d.locked = 1'b1;
							end
							CMD_ENTER_EDIT: begin
								s_d.edit_mode = 1'b1;
							end
							CMD_LEAVE_EDIT: begin
								if (s_q.edit_mode) begin
									s_d.edit_mode = 1'b0;
									s_d.reg_ctl = s_q.reg_default & REGCTL_MASK;
								end
							end
							default: begin
							end
						endcase
					end
				end
				ADDR_KEY_PAIR: begin
					if (s_q.locked) begin
						s_d.bresp = RESP_SLVERR;
					end else begin
						s_d.key_pair = merge(s_q.key_pair, s_q.w_data, s_q.w_strb);
					end
				end
				ADDR_RECOVERY: begin
					if (s_q.locked) begin
						s_d.bresp = RESP_SLVERR;
					end else begin
						m = merge({24'h000000, s_q.recovery}, s_q.w_data, s_q.w_strb);
						s_d.recovery = m[7:0] & RECOVERY_MASK;
					end
				end
				ADDR_REG_CTL: begin
					m = merge({24'h000000, s_q.reg_ctl}, s_q.w_data, s_q.w_strb);
					s_d.reg_ctl = m[7:0] & REGCTL_MASK;
				end
				ADDR_REG_DEFAULT: begin
					// stored defaults are only edited in settings-edit mode
					if (s_q.locked || !s_q.edit_mode) begin
						s_d.bresp = RESP_SLVERR;
					end else begin
						m = merge({24'h000000, s_q.reg_default}, s_q.w_data, s_q.w_strb);
						s_d.reg_default = m[7:0] & REGCTL_MASK;
					end
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// device reset: modes back to power-on, regulator from defaults, key kept
		if (soft_reset) begin
			s_d.locked = LOCKED_RESET;
			s_d.edit_mode = 1'b0;
			s_d.autonomous = AUTONOMOUS_RESET;
			s_d.key_stage = 1'b0;
			s_d.recovery = 8'h00;
			s_d.reg_ctl = s_q.reg_default & REGCTL_MASK;
			s_d.dev_reset = 1'b1;
		end

		s_d.reg_mv = sau_vsel_mv(s_d.reg_ctl[2:0]);
		s_d.awready = !s_d.aw_have;
		s_d.wready = !s_d.w_have;

		// read channel, one outstanding read
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			s_d.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				ADDR_PART_ID: begin
					s_d.rdata = {16'h0000, PART_ID};
				end
				ADDR_FW_LOW: begin
					// legacy copy of the id is byte-swapped
					s_d.rdata = {FIRMWARE_REVISION_WORDS, PART_ID[7:0], PART_ID[15:8]};
				end
				ADDR_FW_HIGH: begin
					s_d.rdata = {16'h0000, BUILD_NUM};
				end
				ADDR_SI_REV: begin
					s_d.rdata = {16'h0000, SI_REV};
				end
				ADDR_RECOVERY: begin
					s_d.rdata = {24'h000000, s_q.recovery};
				end
				ADDR_REG_CTL: begin
					s_d.rdata = {24'h000000, s_q.reg_ctl};
				end
				ADDR_REG_DEFAULT: begin
					s_d.rdata = {24'h000000, s_q.reg_default};
				end
				ADDR_STATUS: begin
					s_d.rdata[ST_LOCKED_BIT] = s_q.locked;
					s_d.rdata[ST_EDIT_BIT] = s_q.edit_mode;
					s_d.rdata[ST_AUTO_BIT] = s_q.autonomous;
					s_d.rdata[ST_KEY_BIT] = s_q.key_stage;
				end
				ADDR_COMMAND, ADDR_KEY_PAIR: begin
					// write-only, key never readable
					s_d.rdata = 32'h0000_0000;
				end
				default: begin
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = s_q.rdata;
	assign aux_regulator_output = s_q.reg_ctl[REGCTL_EN_BIT];
	assign regulator_voltage_select = s_q.reg_ctl[2:0];
	assign regulator_millivolts = s_q.reg_mv;
	assign ts_pullup_on = s_q.reg_ctl[REGCTL_TS_BIT];
	assign unlocked_access_mode = !s_q.locked;
	assign settings_edit_mode = s_q.edit_mode;
	assign autonomous_switch_control = s_q.autonomous;
	assign device_reset_pulse = s_q.dev_reset;
	assign cell_voltage_recovery = s_q.recovery[7];
	assign diagnostic_recovery = s_q.recovery[6];
	assign short_circuit_recovery = s_q.recovery[5];
	assign discharge_overcurrent_one_recovery = s_q.recovery[4];
	assign discharge_overcurrent_two_recovery = s_q.recovery[3];
	assign charge_overcurrent_recovery = s_q.recovery[2];
	assign temperature_recovery = s_q.recovery[1];

	// protection attributes are not used by this slave
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

/* File: verif/sau_monitor.sv */
// sau_monitor: mode, regulator and handshake assertions bound to sau_top
`timescale 1ns/1ps
module sau_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	// watched outputs
	input wire logic aux_regulator_output,
	input wire logic [2:0] regulator_voltage_select,
	input wire logic [12:0] regulator_millivolts,
	input wire logic unlocked_access_mode,
	input wire logic settings_edit_mode,
	input wire logic autonomous_switch_control,
	input wire logic device_reset_pulse,
	input wire logic cell_voltage_recovery,
	input wire logic temperature_recovery
);
	localparam logic [12:0] MV [8] = '{13'h0708, 13'h0708, 13'h0708, 13'h0708, 13'h09C4, 13'h0BB8,
		13'h0CE4, 13'h1388};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_millivolt_decode: assert property (
		$stable(regulator_voltage_select) |=> regulator_millivolts == MV[regulator_voltage_select])
		else $error("regulator millivolts do not match select");
	a_regulator_by_write: assert property (
		$changed(aux_regulator_output) |-> ##[0:1] s_axi_bvalid)
		else $error("regulator enable moved without a write");
	a_recovery_guarded: assert property (
		$changed({cell_voltage_recovery, temperature_recovery}) |-> $past(unlocked_access_mode))
		else $error("recovery bits moved while locked");
	a_unlock_on_write: assert property (
		$rose(unlocked_access_mode) |-> ##[0:1] s_axi_bvalid)
		else $error("unlock without a write");
	a_lock_on_write: assert property (
		$fell(unlocked_access_mode) |-> ##[0:1] s_axi_bvalid)
		else $error("lock without a write");
	a_edit_needs_unlock: assert property (
		$rose(settings_edit_mode) |-> $past(unlocked_access_mode))
		else $error("edit entered while locked");
	a_toggle_guarded: assert property (
		$changed(autonomous_switch_control) |-> $past(unlocked_access_mode))
		else $error("switch control moved while locked");
	a_reset_pulse_once: assert property (
		device_reset_pulse |=> !device_reset_pulse && !unlocked_access_mode && !settings_edit_mode)
		else $error("reset pulse wrong");
	a_aw_busy: assert property (
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address taken twice");
endmodule
bind sau_top sau_monitor u_mon (.*);

/* File: verif/sau_host_model.sv */
// sau_host_model: axi4-lite host issuing subcommand and register cycles
`timescale 1ns/1ps
module sau_host_model (
	// clock
	input wire logic clk_sys,
	// write
	output logic [11:0] s_axi_awaddr = 12'h000,
	output logic s_axi_awvalid = 1'b0,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0,
	output logic [3:0] s_axi_wstrb = 4'h0,
	output logic s_axi_wvalid = 1'b0,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready = 1'b0,
	// read
	output logic [11:0] s_axi_araddr = 12'h000,
	output logic s_axi_arvalid = 1'b0,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready = 1'b0
);
	// each channel dropped only at its own handshake edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
endmodule

/* File: verif/sau_top_tb_top.sv */
// sau_top_tb_top: self-checking bench for the access and unlock block
`timescale 1ns/1ps
module sau_top_tb_top import sau_pkg::*;;
	localparam logic [15:0] P_ID = 16'h3C5A; // arbitrary
	localparam logic [15:0] P_FW = 16'h0203;
	localparam logic [15:0] P_BLD = 16'h0042;
	localparam logic [15:0] P_SI = 16'h0007; // arbitrary
	localparam logic [15:0] K1 = 16'h7E11;
	localparam logic [15:0] K2 = 16'h6D22;
	localparam logic [12:0] MV [8] = '{13'h0708, 13'h0708, 13'h0708, 13'h0708, 13'h09C4, 13'h0BB8,
		13'h0CE4, 13'h1388};
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic aux_regulator_output, unlocked_access_mode, settings_edit_mode;
	logic autonomous_switch_control, device_reset_pulse, cell_voltage_recovery, diagnostic_recovery;
	logic short_circuit_recovery, discharge_overcurrent_one_recovery, temperature_recovery;
	logic discharge_overcurrent_two_recovery, charge_overcurrent_recovery;
	logic [2:0] regulator_voltage_select;
	logic [12:0] regulator_millivolts;
	logic ts_pullup_on;
	wire [9:0] modes = {unlocked_access_mode, settings_edit_mode, autonomous_switch_control,
		cell_voltage_recovery, diagnostic_recovery, short_circuit_recovery,
		discharge_overcurrent_one_recovery, discharge_overcurrent_two_recovery,
		charge_overcurrent_recovery, temperature_recovery};
	wire [16:0] regs = {aux_regulator_output, regulator_voltage_select, regulator_millivolts};
	int errors = 0;
	int checks_done = 0;
	int pulses = 0;
	int seed = 50;
	int cyc = 0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [7:0] rv;

	// short unlock window keeps the timeout case cheap
	sau_top #(.PART_ID(P_ID), .FIRMWARE_REVISION_WORDS(P_FW), .BUILD_NUM(P_BLD), .SI_REV(P_SI),
		.KEY_FIRST_INIT(K1), .KEY_SECOND_INIT(K2), .KEY_TIMEOUT_CYC(50)) dut (.*);
	sau_host_model host (.*);

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		host.wr(a, d);
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		host.rd(a);
		@(negedge clk_sys);
	endtask
	task automatic cmd(input logic [15:0] c);
		wr(ADDR_COMMAND, {16'h0, c}, RESP_OKAY);
	endtask

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// response watcher: oldest note against each completed beat
	always @(posedge clk_sys) begin
		cyc++;
		if (device_reset_pulse === 1'b1) pulses++;
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) check(s_axi_bresp, bq.pop_front());
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		end
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check(modes, 10'h000);
		check(regs, {1'b1, 3'h0, 13'h0708});
		rd(ADDR_PART_ID, {16'h0, P_ID}, RESP_OKAY);
		rd(ADDR_FW_LOW, {P_FW, P_ID[7:0], P_ID[15:8]}, RESP_OKAY);
		rd(ADDR_FW_HIGH, {16'h0, P_BLD}, RESP_OKAY);
		rd(ADDR_SI_REV, {16'h0, P_SI}, RESP_OKAY);
		rd(12'h200, 32'h0, RESP_SLVERR);
		rd(ADDR_STATUS, 32'h1, RESP_OKAY);
		rd(ADDR_REG_DEFAULT, {24'h0, REG_DEFAULT_RESET}, RESP_OKAY);
		rd(ADDR_KEY_PAIR, 32'h0, RESP_OKAY);
		wr(ADDR_PART_ID, 32'h0, RESP_SLVERR);
		wr(ADDR_RECOVERY, 32'hFE, RESP_SLVERR);
		wr(ADDR_KEY_PAIR, 32'h0, RESP_SLVERR);
		cmd(CMD_SWITCH_TOGGLE);
		cmd(CMD_ENTER_EDIT);
		check(modes, 10'h000);
		cmd(K1);
		// a read leaves the pending first word alone
		rd(ADDR_STATUS, 32'h9, RESP_OKAY);
		cmd(16'h0BAD);
		cmd(K2);
		cmd(K1);
		wr(ADDR_REG_CTL, 32'h08, RESP_OKAY);
		cmd(K2);
		cmd(K1);
		repeat (60) @(posedge clk_sys);
		cmd(K2);
		check(modes, 10'h000);
		cmd(K1);
		cmd(K2);
		check(modes, 10'h200);
		cmd(CMD_SWITCH_TOGGLE);
		check(modes, 10'h280);
		rd(ADDR_STATUS, 32'h4, RESP_OKAY);
		for (int i = 1; i < 8; i++) begin
			rv = 8'h01 << i;
			wr(ADDR_RECOVERY, {24'h0, rv}, RESP_OKAY);
			check(modes, {3'b101, rv[7:1]});
		end
		wr(ADDR_RECOVERY, 32'hFF, RESP_OKAY);
		rd(ADDR_RECOVERY, 32'hFE, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			rv = {1'($random(seed)), 2'h0, 1'($random(seed)), 1'($random(seed)), 3'(i)};
			wr(ADDR_REG_CTL, {24'h0, rv}, RESP_OKAY);
			check({ts_pullup_on, regs}, {rv[4], rv[3], rv[2:0], MV[rv[2:0]]});
			rd(ADDR_REG_CTL, {24'h0, rv & REGCTL_MASK}, RESP_OKAY);
		end
		cmd(CMD_ENTER_EDIT);
		check(modes[8], 1'b1);
		wr(ADDR_REG_DEFAULT, 32'h0D, RESP_OKAY);
		cmd(CMD_LEAVE_EDIT);
		check({modes[8], regs}, {1'b0, 1'b1, 3'h5, 13'h0BB8});
		// defaults frozen outside edit; leave-edit outside edit must not reload
		wr(ADDR_REG_DEFAULT, 32'h0F, RESP_SLVERR);
		wr(ADDR_REG_CTL, 32'h00, RESP_OKAY);
		cmd(CMD_LEAVE_EDIT);
		check(regs, {1'b0, 3'h0, 13'h0708});
		wr(ADDR_KEY_PAIR, {K1, K2}, RESP_OKAY);
		cmd(CMD_RESET);
		check({modes, pulses[1:0]}, {10'h000, 2'h1});
		check(regs, {1'b1, 3'h5, 13'h0BB8});
		cmd(K2);
		cmd(K1);
		check(modes[9], 1'b1);
		cmd(CMD_LOCK);
		check(modes[9], 1'b0);
		cmd(CMD_RESET);
		check(pulses, 1);
		complete_run();
	end
endmodule
